//--- dcs_params.svh
// Register indexes, field positions, reset values and timing figures of the DC servo.
// Included by the package and by the servo control module.
`ifndef DCS_PARAMS_SVH
`define DCS_PARAMS_SVH

// Register indexes; the byte address on the bus is four times the index.
`define DCS_IDX_ENABLE      10'h043
`define DCS_IDX_TRIGGER     10'h044
`define DCS_IDX_INTERVAL    10'h045
`define DCS_IDX_LINE_COUNT  10'h047
`define DCS_IDX_HP_COUNT    10'h048
`define DCS_IDX_VALUE_3     10'h049
`define DCS_IDX_VALUE_2     10'h04A
`define DCS_IDX_VALUE_1     10'h04B
`define DCS_IDX_VALUE_0     10'h04C
`define DCS_IDX_IRQ_STATUS  10'h050
`define DCS_IDX_IRQ_ENABLE  10'h051
`define DCS_IDX_IRQ_CLEAR   10'h052

// Field positions.
`define DCS_SINGLE_LSB      12
`define DCS_SERIES_LSB      8
`define DCS_LINE_PER_LSB    8
`define DCS_HP_PER_LSB      0

// Reset values.
`define DCS_PERIOD_RESET    4'hA
`define DCS_COUNT_RESET     7'h2A

// Timing: base tick of the periodic timers and length of one measurement.
`define DCS_TICK_NS         256000000
`define DCS_CLK_NS          40
`define DCS_MEAS_CYCLES     5'h10

`endif

//--- dcs_pkg.sv
// Types shared by the DC servo active-mode control.
// Expects dcs_params.svh on the include path.
`include "dcs_params.svh"

package dcs_pkg;

  typedef enum logic [1:0] {DCS_IDLE, DCS_SINGLE, DCS_SERIES} dcs_mode_t;

  typedef struct packed {
    dcs_mode_t   mode;
    logic [6:0]  left;
    logic [4:0]  meas;
    logic [7:0]  value;
  } dcs_chan_t;

  // Correction values, index 0 headphone left up to 3 line right.
  typedef logic [3:0][7:0] dcs_values_t;

  typedef struct packed {
    dcs_chan_t [3:0]       ch;
    logic [3:0]            enable;
    logic [1:0][3:0]       period;
    logic [1:0][6:0]       count;
    logic [1:0][15:0]      ticks;
    logic [22:0]           tick_cnt;
    logic [3:0]            irq_status;
    logic [3:0]            irq_enable;
    logic                  wr_pend;
    logic [9:0]            idx;
    logic [31:0]           rdata;
  } dcs_state_t;

endpackage

//--- dcs_servo_ctrl.sv
// DC servo active-mode control: single, series and periodic offset corrections
// on four outputs, with an AHB-Lite register slave and a completion interrupt.
// Assumes one clock, a synchronous reset and a comparator per output that says
// whether the measured offset is above zero at the end of each measurement.
//
// Function
// - Servo runs only while channel enable set
// - Single trigger: one measurement, step one LSB
// - Index 3 LR, 2 LL, 1 HR, 0 HL
// - Single triggers bits 15:12, read busy
// - Series trigger runs (count+1)-long measurement sequence
// - Series triggers bits 11:8, read busy
// - Series count N gives N+1 updates
// - Separate pair counts, reset to 0x2A
// - Nonzero timer schedules periodic singles; zero off
// - Interval is 0.256 s times 2^period
// - Line period 11:8, headphone 3:0, reset 0xA
// - Read eight-bit two's complement correction values
`timescale 1ns/1ns
`include "dcs_params.svh"

module dcs_servo_ctrl #(
  parameter int TICK_CYCLES = `DCS_TICK_NS / `DCS_CLK_NS
) (
  // Clock and reset.
  input  wire logic                CLK,
  input  wire logic                RESET,
  // AHB-Lite slave.
  input  wire logic                HSEL,
  input  wire logic [31:0]         HADDR,
  input  wire logic [1:0]          HTRANS,
  input  wire logic                HWRITE,
  input  wire logic [2:0]          HSIZE,
  input  wire logic [31:0]         HWDATA,
  input  wire logic                HREADY,
  output logic      [31:0]         HRDATA,
  output logic                     HREADYOUT,
  output logic                     HRESP,
  // Measurement circuit.
  input  wire logic [3:0]          OFFSET_ABOVE,
  output logic      [3:0]          MEASURE_ACTIVE,
  output dcs_pkg::dcs_values_t     OFFSET_CORRECTION_VALUE,
  // Interrupt.
  output logic                     IRQ
);

  localparam logic [22:0] TICK_LAST = 23'(TICK_CYCLES - 1);

  dcs_pkg::dcs_state_t s_q;
  dcs_pkg::dcs_state_t s_d;

  logic       addr_phase;
  logic       wr_hit;
  logic [1:0] fire;
  logic [3:0] trig_single;
  logic [3:0] trig_series;
  logic [3:0] done;
  logic       tick;
  logic [31:0] rd;

  // Number of base ticks in one periodic interval, less one.
  function automatic logic [15:0] interval_last(input logic [3:0] per);
    interval_last = 16'((17'h1 << per) - 17'h1);
  endfunction

  // One correction step, saturating at the ends of the two's complement range.
  function automatic logic [7:0] servo_step(input logic [7:0] v, input logic above);
    if (above) begin
      servo_step = (v == 8'h80) ? v : v - 8'h01;
    end else begin
      servo_step = (v == 8'h7F) ? v : v + 8'h01;
    end
  endfunction

  always_comb begin
    s_d = s_q;
    addr_phase = HSEL && HTRANS[1] && HREADY;
    wr_hit = s_q.wr_pend;
    rd = 32'h0000_0000;

    // Base tick and the two pair interval timers.
    tick = (s_q.tick_cnt == TICK_LAST);
    s_d.tick_cnt = tick ? 23'h000000 : s_q.tick_cnt + 23'h000001;
    for (int p = 0; p < 2; p++) begin
      fire[p] = 1'b0;
      if (s_q.period[p] == 4'h0) begin
        s_d.ticks[p] = 16'h0000;
      end else if (tick) begin
        if (s_q.ticks[p] >= interval_last(s_q.period[p])) begin
          fire[p] = 1'b1;
          s_d.ticks[p] = 16'h0000;
        end else begin
          s_d.ticks[p] = s_q.ticks[p] + 16'h0001;
        end
      end
    end

    trig_single = 4'h0;
    trig_series = 4'h0;
    if (wr_hit && s_q.idx == `DCS_IDX_TRIGGER) begin
      trig_single = HWDATA[`DCS_SINGLE_LSB +: 4];
      trig_series = HWDATA[`DCS_SERIES_LSB +: 4];
    end

    // Per-channel engines; channel n belongs to pair n/2.
    done = 4'h0;
    for (int n = 0; n < 4; n++) begin
      if (!s_q.enable[n]) begin
        s_d.ch[n].mode = dcs_pkg::DCS_IDLE;
        s_d.ch[n].meas = 5'h00;
      end else begin
        case (s_q.ch[n].mode)
          dcs_pkg::DCS_IDLE: begin
            if (trig_series[n]) begin
              s_d.ch[n].mode = dcs_pkg::DCS_SERIES;
              s_d.ch[n].left = s_q.count[n / 2];
              s_d.ch[n].meas = `DCS_MEAS_CYCLES;
            end else if (trig_single[n] || fire[n / 2]) begin
              s_d.ch[n].mode = dcs_pkg::DCS_SINGLE;
              s_d.ch[n].meas = `DCS_MEAS_CYCLES;
            end
          end
          default: begin
            if (s_q.ch[n].meas != 5'h00) begin
              s_d.ch[n].meas = s_q.ch[n].meas - 5'h01;
            end else begin
              s_d.ch[n].value = servo_step(s_q.ch[n].value, OFFSET_ABOVE[n]);
              if (s_q.ch[n].mode == dcs_pkg::DCS_SINGLE || s_q.ch[n].left == 7'h00) begin
                s_d.ch[n].mode = dcs_pkg::DCS_IDLE;
                done[n] = 1'b1;
              end else begin
                s_d.ch[n].left = s_q.ch[n].left - 7'h01;
                s_d.ch[n].meas = `DCS_MEAS_CYCLES;
              end
            end
          end
        endcase
      end
    end

    // Register writes in the data phase.
    if (wr_hit) begin
      if (s_q.idx == `DCS_IDX_ENABLE) begin
        s_d.enable = HWDATA[3:0];
      end else if (s_q.idx == `DCS_IDX_INTERVAL) begin
        s_d.period[1] = HWDATA[`DCS_LINE_PER_LSB +: 4];
        s_d.period[0] = HWDATA[`DCS_HP_PER_LSB +: 4];
      end else if (s_q.idx == `DCS_IDX_LINE_COUNT) begin
        s_d.count[1] = HWDATA[6:0];
      end else if (s_q.idx == `DCS_IDX_HP_COUNT) begin
        s_d.count[0] = HWDATA[6:0];
      end else if (s_q.idx == `DCS_IDX_IRQ_ENABLE) begin
        s_d.irq_enable = HWDATA[3:0];
      end
    end

    // A completion in the cycle of a clear keeps its status bit set.
    s_d.irq_status = s_q.irq_status | done;
    if (wr_hit && s_q.idx == `DCS_IDX_IRQ_CLEAR) begin
      s_d.irq_status = (s_q.irq_status & ~HWDATA[3:0]) | done;
    end

    // Read decode in the address phase; unmapped addresses read zero.
    if (HADDR[11:2] == `DCS_IDX_ENABLE) begin
      rd = {28'h0000000, s_q.enable};
    end else if (HADDR[11:2] == `DCS_IDX_TRIGGER) begin
      for (int n = 0; n < 4; n++) begin
        rd[`DCS_SINGLE_LSB + n] = (s_q.ch[n].mode == dcs_pkg::DCS_SINGLE);
        rd[`DCS_SERIES_LSB + n] = (s_q.ch[n].mode == dcs_pkg::DCS_SERIES);
      end
    end else if (HADDR[11:2] == `DCS_IDX_INTERVAL) begin
      rd = {20'h00000, s_q.period[1], 4'h0, s_q.period[0]};
    end else if (HADDR[11:2] == `DCS_IDX_LINE_COUNT) begin
      rd = {25'h0000000, s_q.count[1]};
    end else if (HADDR[11:2] == `DCS_IDX_HP_COUNT) begin
      rd = {25'h0000000, s_q.count[0]};
    end else if (HADDR[11:2] == `DCS_IDX_VALUE_3) begin
      rd = {24'h000000, s_q.ch[3].value};
    end else if (HADDR[11:2] == `DCS_IDX_VALUE_2) begin
      rd = {24'h000000, s_q.ch[2].value};
    end else if (HADDR[11:2] == `DCS_IDX_VALUE_1) begin
      rd = {24'h000000, s_q.ch[1].value};
    end else if (HADDR[11:2] == `DCS_IDX_VALUE_0) begin
      rd = {24'h000000, s_q.ch[0].value};
    end else if (HADDR[11:2] == `DCS_IDX_IRQ_STATUS) begin
      rd = {28'h0000000, s_q.irq_status};
    end else if (HADDR[11:2] == `DCS_IDX_IRQ_ENABLE) begin
      rd = {28'h0000000, s_q.irq_enable};
    end

    s_d.wr_pend = addr_phase && HWRITE;
    if (addr_phase) begin
      s_d.idx = HADDR[11:2];
      if (!HWRITE) begin
        s_d.rdata = rd;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      s_q <= '0;
      s_q.period <= {`DCS_PERIOD_RESET, `DCS_PERIOD_RESET};
      s_q.count <= {`DCS_COUNT_RESET, `DCS_COUNT_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  assign HRDATA = s_q.rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign IRQ = |(s_q.irq_status & s_q.irq_enable);
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      MEASURE_ACTIVE[n] = (s_q.ch[n].mode != dcs_pkg::DCS_IDLE);
      OFFSET_CORRECTION_VALUE[n] = s_q.ch[n].value;
    end
  end

  // Checks per channel.
  for (genvar g = 0; g < 4; g++) begin : g_chk
    chan_off_a: assert property (@(posedge CLK) disable iff (RESET)
      !s_q.enable[g] |=> s_q.ch[g].mode == dcs_pkg::DCS_IDLE && $stable(s_q.ch[g].value))
      else $error("Disabled channel kept running.");

    step_size_a: assert property (@(posedge CLK) disable iff (RESET)
      s_q.ch[g].value != $past(s_q.ch[g].value) |->
        (8'(s_q.ch[g].value - $past(s_q.ch[g].value)) inside {8'h01, 8'hFF}))
      else $error("Correction moved by more than one step.");

    series_load_a: assert property (@(posedge CLK) disable iff (RESET)
      $past(s_q.ch[g].mode) == dcs_pkg::DCS_IDLE && s_q.ch[g].mode == dcs_pkg::DCS_SERIES
        |-> s_q.ch[g].left == $past(s_q.count[g / 2]))
      else $error("Series did not load the pair count.");

    single_clear_a: assert property (@(posedge CLK) disable iff (RESET)
      s_q.ch[g].mode == dcs_pkg::DCS_SINGLE && s_q.ch[g].meas == 5'h00 && s_q.enable[g]
        |=> s_q.ch[g].mode == dcs_pkg::DCS_IDLE && s_q.irq_status[g])
      else $error("Single correction did not finish.");

    series_end_a: assert property (@(posedge CLK) disable iff (RESET)
      s_q.ch[g].mode == dcs_pkg::DCS_SERIES && s_q.ch[g].left == 7'h00 &&
        s_q.ch[g].meas == 5'h00 && s_q.enable[g] |=> s_q.ch[g].mode == dcs_pkg::DCS_IDLE)
      else $error("Series ran past its last update.");

    meas_len_a: assert property (@(posedge CLK) disable iff (RESET)
      $rose(MEASURE_ACTIVE[g]) && s_q.enable[g] |-> s_q.ch[g].meas == `DCS_MEAS_CYCLES)
      else $error("Measurement did not start at full length.");

    // A measurement in flight holds its mode and its correction until its last cycle.
    meas_hold_a: assert property (@(posedge CLK) disable iff (RESET)
      s_q.enable[g] && s_q.ch[g].mode != dcs_pkg::DCS_IDLE && s_q.ch[g].meas != 5'h00
        |=> $stable(s_q.ch[g].mode) && $stable(s_q.ch[g].value))
      else $error("Correction moved before the measurement ended.");

    value_idle_a: assert property (@(posedge CLK) disable iff (RESET)
      s_q.ch[g].mode == dcs_pkg::DCS_IDLE |=> $stable(s_q.ch[g].value))
      else $error("Idle channel changed its correction.");

    series_start_a: assert property (@(posedge CLK) disable iff (RESET)
      s_q.enable[g] && s_q.ch[g].mode == dcs_pkg::DCS_IDLE && trig_series[g]
        |=> s_q.ch[g].mode == dcs_pkg::DCS_SERIES)
      else $error("Series trigger did not start a series.");

    single_start_a: assert property (@(posedge CLK) disable iff (RESET)
      s_q.enable[g] && s_q.ch[g].mode == dcs_pkg::DCS_IDLE && !trig_series[g] &&
        trig_single[g] |=> s_q.ch[g].mode == dcs_pkg::DCS_SINGLE)
      else $error("Single trigger did not start a correction.");

    periodic_start_a: assert property (@(posedge CLK) disable iff (RESET)
      s_q.enable[g] && s_q.ch[g].mode == dcs_pkg::DCS_IDLE && !trig_series[g] &&
        fire[g / 2] |=> s_q.ch[g].mode == dcs_pkg::DCS_SINGLE)
      else $error("Periodic update did not start a correction.");

    series_step_a: assert property (@(posedge CLK) disable iff (RESET)
      s_q.enable[g] && s_q.ch[g].mode == dcs_pkg::DCS_SERIES && s_q.ch[g].meas == 5'h00 &&
        s_q.ch[g].left != 7'h00 |=> s_q.ch[g].mode == dcs_pkg::DCS_SERIES &&
        s_q.ch[g].left == $past(s_q.ch[g].left) - 7'h01 && s_q.ch[g].meas == `DCS_MEAS_CYCLES)
      else $error("Series did not move on to its next update.");

    status_keep_a: assert property (@(posedge CLK) disable iff (RESET)
      s_q.irq_status[g] && !(wr_hit && s_q.idx == `DCS_IDX_IRQ_CLEAR && HWDATA[g])
        |=> s_q.irq_status[g])
      else $error("Status bit dropped without a clear.");

    status_clear_a: assert property (@(posedge CLK) disable iff (RESET)
      wr_hit && s_q.idx == `DCS_IDX_IRQ_CLEAR && HWDATA[g] && !done[g]
        |=> !s_q.irq_status[g])
      else $error("Status bit survived its clear.");
  end

  for (genvar p = 0; p < 2; p++) begin : g_pair
    period_off_a: assert property (@(posedge CLK) disable iff (RESET)
      s_q.period[p] == 4'h0 |=> s_q.ticks[p] == 16'h0000)
      else $error("Disabled timer kept counting.");

    period_wrap_a: assert property (@(posedge CLK) disable iff (RESET)
      s_q.period[p] != 4'h0 && s_q.tick_cnt == TICK_LAST &&
        s_q.ticks[p] == interval_last(s_q.period[p]) |=> s_q.ticks[p] == 16'h0000)
      else $error("Interval timer did not wrap.");

    fire_cond_a: assert property (@(posedge CLK) disable iff (RESET)
      fire[p] |-> tick && s_q.period[p] != 4'h0)
      else $error("Periodic update fired off a base tick.");

    ticks_hold_a: assert property (@(posedge CLK) disable iff (RESET)
      s_q.period[p] != 4'h0 && !tick |=> $stable(s_q.ticks[p]))
      else $error("Interval timer moved between base ticks.");
  end

  reset_vals_a: assert property (@(posedge CLK)
    $past(RESET) && !RESET |-> s_q.count[0] == `DCS_COUNT_RESET &&
      s_q.count[1] == `DCS_COUNT_RESET && s_q.period[1] == `DCS_PERIOD_RESET)
    else $error("Counts or periods wrong after reset.");

  trig_read_a: assert property (@(posedge CLK) disable iff (RESET)
    HSEL && HTRANS[1] && HREADY && !HWRITE && HADDR[11:2] == `DCS_IDX_TRIGGER
      |=> HRDATA[`DCS_SINGLE_LSB] == ($past(s_q.ch[0].mode) == dcs_pkg::DCS_SINGLE) &&
        HRDATA[`DCS_SERIES_LSB + 3] == ($past(s_q.ch[3].mode) == dcs_pkg::DCS_SERIES))
    else $error("Trigger readback does not show busy state.");

  // Register writes land at the edge that ends the data phase.
  enable_write_a: assert property (@(posedge CLK) disable iff (RESET)
    wr_hit && s_q.idx == `DCS_IDX_ENABLE |=> s_q.enable == $past(HWDATA[3:0]))
    else $error("Enable write did not land.");

  period_write_a: assert property (@(posedge CLK) disable iff (RESET)
    wr_hit && s_q.idx == `DCS_IDX_INTERVAL
      |=> s_q.period[1] == $past(HWDATA[`DCS_LINE_PER_LSB +: 4]) &&
      s_q.period[0] == $past(HWDATA[`DCS_HP_PER_LSB +: 4]))
    else $error("Interval write did not land.");

  line_count_a: assert property (@(posedge CLK) disable iff (RESET)
    wr_hit && s_q.idx == `DCS_IDX_LINE_COUNT |=> s_q.count[1] == $past(HWDATA[6:0]) &&
      s_q.count[0] == $past(s_q.count[0]))
    else $error("Line pair count write went astray.");

  hp_count_a: assert property (@(posedge CLK) disable iff (RESET)
    wr_hit && s_q.idx == `DCS_IDX_HP_COUNT |=> s_q.count[0] == $past(HWDATA[6:0]) &&
      s_q.count[1] == $past(s_q.count[1]))
    else $error("Headphone pair count write went astray.");

  irq_enable_a: assert property (@(posedge CLK) disable iff (RESET)
    wr_hit && s_q.idx == `DCS_IDX_IRQ_ENABLE |=> s_q.irq_enable == $past(HWDATA[3:0]))
    else $error("Interrupt enable write did not land.");

endmodule

//--- tb.sv
// Self-checking testbench for the DC servo active-mode control.
// Drives the AHB-Lite slave and the per-channel comparator inputs itself.
`timescale 1ns/1ns
`include "dcs_params.svh"

module tb;
  logic                 CLK = 1'b0;
  logic                 RESET = 1'b1;
  logic                 HSEL = 1'b0;
  logic [31:0]          HADDR = 32'h0;
  logic [1:0]           HTRANS = 2'h0;
  logic                 HWRITE = 1'b0;
  logic [31:0]          HWDATA = 32'h0;
  logic [3:0]           OFFSET_ABOVE = 4'h0;
  logic [31:0]          HRDATA;
  logic                 HREADYOUT;
  logic                 HRESP;
  logic [3:0]           MEASURE_ACTIVE;
  dcs_pkg::dcs_values_t OFFSET_CORRECTION_VALUE;
  logic                 IRQ;
  int                   failures = 0;
  int                   samples_checked = 0;
  int                   cycles = 0;
  int                   act [4] = '{default: 0};
  logic [7:0]           mv [4] = '{default: 8'h00};
  logic [31:0]          rd;

  always #20 CLK = ~CLK;

  dcs_servo_ctrl #(.TICK_CYCLES(4)) dut (
    .CLK(CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .OFFSET_ABOVE(OFFSET_ABOVE), .MEASURE_ACTIVE(MEASURE_ACTIVE),
    .OFFSET_CORRECTION_VALUE(OFFSET_CORRECTION_VALUE), .IRQ(IRQ)
  );

  // Counts measurement cycles per channel and cuts a hang short.
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    for (int i = 0; i < 4; i++) begin
      act[i] <= act[i] + int'(MEASURE_ACTIVE[i]);
    end
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {20'h0, idx, 2'h0};
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask

  task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp, input string name);
    bus(1'b0, idx, 32'h0);
    chk(name, rd, exp);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    @(posedge CLK);
    while (MEASURE_ACTIVE !== 4'h0 && n < 5000) begin
      @(posedge CLK);
      n++;
    end
    @(posedge CLK);
  endtask

  task automatic wait_lvl(input logic b, output int n);
    n = 0;
    while (MEASURE_ACTIVE[0] !== b && n < 300) begin
      @(posedge CLK);
      n++;
    end
  endtask

  task automatic chk_values();
    for (int i = 0; i < 4; i++) begin
      rdchk(10'(`DCS_IDX_VALUE_0 - i), {24'h0, mv[i]}, "value reg");
      chk("value port", {24'h0, OFFSET_CORRECTION_VALUE[i]}, {24'h0, mv[i]});
    end
  endtask

  task automatic t_reset();
    rdchk(`DCS_IDX_INTERVAL, 32'h0000_0A0A, "interval reset");
    rdchk(`DCS_IDX_LINE_COUNT, 32'h2A, "line count reset");
    rdchk(`DCS_IDX_HP_COUNT, 32'h2A, "hp count reset");
    rdchk(`DCS_IDX_TRIGGER, 32'h0, "trigger reset");
    chk_values();
    rdchk(10'h046, 32'h0, "unmapped");
    rdchk(`DCS_IDX_ENABLE, 32'h0, "enable reset");
    chk("irq reset", {31'h0, IRQ}, 32'h0);
    chk("hready out", {31'h0, HREADYOUT}, 32'h1);
    chk("hresp okay", {31'h0, HRESP}, 32'h0);
    bus(1'b1, `DCS_IDX_INTERVAL, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_single();
    int a;
    OFFSET_ABOVE <= 4'h5;
    bus(1'b1, `DCS_IDX_ENABLE, 32'hF);
    a = act[0];
    bus(1'b1, `DCS_IDX_TRIGGER, 32'h0000_F000);
    rdchk(`DCS_IDX_TRIGGER, 32'h0000_F000, "single busy");
    wait_idle();
    chk("single length", act[0] - a, 17);
    rdchk(`DCS_IDX_TRIGGER, 32'h0, "single cleared");
    mv = '{8'hFF, 8'h01, 8'hFF, 8'h01};
    chk_values();
    $display("test single done");
  endtask

  task automatic t_series(input int ch, input logic [9:0] cidx, input int cnt, input logic dn);
    int a;
    OFFSET_ABOVE <= dn ? 4'hF : 4'h0;
    bus(1'b1, cidx, 32'(cnt));
    rdchk(cidx, 32'(cnt), "series count");
    a = act[ch];
    bus(1'b1, `DCS_IDX_TRIGGER, 32'h1 << (8 + ch));
    rdchk(`DCS_IDX_TRIGGER, 32'h1 << (8 + ch), "series busy");
    wait_idle();
    chk("series length", act[ch] - a, 17 * (cnt + 1));
    mv[ch] = dn ? mv[ch] - 8'(cnt + 1) : mv[ch] + 8'(cnt + 1);
    chk_values();
    $display("test series done");
  endtask

  task automatic t_disabled();
    int a;
    bus(1'b1, `DCS_IDX_ENABLE, 32'hE);
    rdchk(`DCS_IDX_ENABLE, 32'hE, "enable readback");
    a = act[0];
    bus(1'b1, `DCS_IDX_TRIGGER, 32'h0000_1100);
    repeat (20) @(posedge CLK);
    chk("disabled activity", act[0] - a, 0);
    chk_values();
    $display("test disabled done");
  endtask

  task automatic t_irq();
    OFFSET_ABOVE <= 4'h0;
    bus(1'b1, `DCS_IDX_IRQ_CLEAR, 32'hF);
    rdchk(`DCS_IDX_IRQ_STATUS, 32'h0, "status cleared");
    bus(1'b1, `DCS_IDX_IRQ_ENABLE, 32'h8);
    rdchk(`DCS_IDX_IRQ_ENABLE, 32'h8, "irq enable");
    bus(1'b1, `DCS_IDX_TRIGGER, 32'h0000_4000);
    wait_idle();
    rdchk(`DCS_IDX_IRQ_STATUS, 32'h4, "status set");
    chk("irq masked", {31'h0, IRQ}, 32'h0);
    bus(1'b1, `DCS_IDX_TRIGGER, 32'h0000_8000);
    wait_idle();
    chk("irq raised", {31'h0, IRQ}, 32'h1);
    bus(1'b1, `DCS_IDX_IRQ_CLEAR, 32'h8);
    @(posedge CLK);
    chk("irq cleared", {31'h0, IRQ}, 32'h0);
    mv[2] = mv[2] + 8'h01;
    mv[3] = mv[3] + 8'h01;
    chk_values();
    $display("test irq done");
  endtask

  task automatic t_periodic();
    int n0;
    int n1;
    int n2;
    int a;
    bus(1'b1, `DCS_IDX_ENABLE, 32'hF);
    bus(1'b1, `DCS_IDX_INTERVAL, 32'h0000_0003);
    rdchk(`DCS_IDX_INTERVAL, 32'h3, "interval");
    wait_lvl(1'b1, n0);
    chk("pair fires", {30'h0, MEASURE_ACTIVE[1:0]}, 32'h3);
    wait_lvl(1'b0, n1);
    wait_lvl(1'b1, n2);
    chk("period cycles", n1 + n2, 32);
    chk("line pair off", {30'h0, MEASURE_ACTIVE[3:2]}, 32'h0);
    bus(1'b1, `DCS_IDX_INTERVAL, 32'h0);
    wait_idle();
    a = act[0];
    repeat (100) @(posedge CLK);
    chk("periodic stopped", act[0] - a, 0);
    $display("test periodic done");
  endtask

  initial begin
    repeat (16) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    t_reset();
    t_single();
    t_series(3, `DCS_IDX_LINE_COUNT, 2, 1'b0);
    t_series(1, `DCS_IDX_HP_COUNT, 127, 1'b1);
    rdchk(`DCS_IDX_LINE_COUNT, 32'h2, "line count kept");
    t_disabled();
    t_irq();
    t_periodic();
    summarize();
  end
endmodule
